// ===== lnd_pkg.sv
// lnd_pkg: constants, field layouts and carriers for the nvm defaults loader
// assumes a 20 MHz core clock and a 16-bit word nonvolatile store
package lnd_pkg;

  // clock and blink timing
  localparam int CLK_KHZ = 20000;
  localparam int BLINK_SLOW_MS = 200;
  localparam int BLINK_FAST_MS = 83;
  localparam int BLINK_SLOW_CYC = BLINK_SLOW_MS * CLK_KHZ;
  localparam int BLINK_FAST_CYC = BLINK_FAST_MS * CLK_KHZ;
  localparam int BLINK_CNT_W = 23;

  // nvm word indices; bus byte address is four times the index
  localparam logic [7:0] WIDX_ACT_LED = 8'h1c;
  localparam logic [7:0] WIDX_REV_PWR = 8'h1e;
  localparam logic [7:0] WIDX_LINK_LED = 8'h1f;

  // bus byte offsets
  localparam logic [7:0] OFS_LED_CTL = 8'h00;
  localparam logic [7:0] OFS_PWR_CFG = 8'h04;
  localparam logic [7:0] OFS_ID_CFG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_ACT_WORD = {WIDX_ACT_LED[5:0], 2'b00};
  localparam logic [7:0] OFS_REV_WORD = {WIDX_REV_PWR[5:0], 2'b00};
  localparam logic [7:0] OFS_LINK_WORD = {WIDX_LINK_LED[5:0], 2'b00};

  // activity word fields
  localparam int ACT_BLINK_BIT = 7;
  localparam int ACT_FLIP_BIT = 6;
  localparam int ACT_SEL_LSB = 0;
  // revision word fields
  localparam int STATIC_OFF_BIT = 15;
  localparam int DYN_OFF_BIT = 14;
  localparam int CLASS_SEL_BIT = 11;
  localparam int PHY_POL_LSB = 8;
  localparam int REV_XOR_LSB = 0;
  // link word fields
  localparam int GIG_BLINK_BIT = 15;
  localparam int GIG_FLIP_BIT = 14;
  localparam int GIG_SEL_LSB = 8;
  localparam int LINK_BLINK_BIT = 7;
  localparam int LINK_FLIP_BIT = 6;
  localparam int BLINK_RATE_BIT = 5;
  localparam int LINK_SEL_LSB = 0;

  // status register fields
  localparam int ST_DONE_BIT = 0;
  localparam int ST_PDOWN_BIT = 1;
  localparam int ST_OFFPIN_BIT = 2;
  localparam int ST_REV_LSB = 8;

  // reset values of live fields, and the energy detect policy code
  localparam logic [3:0] ACT_SEL_RST = 4'h4;
  localparam logic [3:0] GIG_SEL_RST = 4'h7;
  localparam logic [3:0] LINK_SEL_RST = 4'h6;
  localparam logic [23:0] LAN_CLASS = 24'h020000;
  localparam logic [1:0] PHY_POL_NONE = 2'h0;
  localparam logic [1:0] PHY_POL_ED = 2'h1;

  // one led channel
  typedef struct packed {
    logic blink_en;
    logic polarity_flip;
    logic [3:0] source_sel;
  } lnd_led_t;

  // led control register image: act, gig, link, shared rate
  typedef struct packed {
    lnd_led_t act;
    lnd_led_t gig;
    lnd_led_t link;
    logic blink_fast;
  } lnd_led_ctl_t;

  // power and identity configuration
  typedef struct packed {
    logic static_off_en;
    logic dynamic_off_en;
    logic [1:0] phy_off_state_policy;
    logic class_alt;
    logic [7:0] revision_xor_value;
  } lnd_pwr_cfg_t;

  typedef enum logic [1:0] {
    LD_REQ = 2'b00,
    LD_WAIT = 2'b01,
    LD_DONE = 2'b10
  } lnd_ld_state_t;

endpackage

// ===== lnd_loader.sv
// lnd_loader: loads led and device-off defaults from nvm, holds live copies
// assumes nvm read port and power inputs on clk_sys, off pin asynchronous
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
module lnd_loader #(
  parameter logic [7:0] HW_REV_ID = 8'h01, // arbitrary value
  parameter logic [23:0] ALT_CLASS = 24'h020000,
  parameter int BLINK_SLOW = lnd_pkg::BLINK_SLOW_CYC,
  parameter int BLINK_FAST = lnd_pkg::BLINK_FAST_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // nvm read port
  output logic nvm_rd_req,
  output logic [7:0] nvm_rd_addr,
  input wire logic [15:0] nvm_rd_data,
  input wire logic nvm_rd_valid,
  // power inputs
  input wire logic power_off_request_n,
  input wire logic pcie_link_dr,
  input wire logic phy_wol_needed,
  // results
  output lnd_pkg::lnd_led_ctl_t led_control_reg,
  output logic blink_phase,
  output logic device_power_down,
  output logic phy_power_down,
  output logic phy_energy_detect,
  output logic [7:0] revision_id,
  output logic [23:0] class_code,
  output logic load_done
);
  import lnd_pkg::*;

  lnd_ld_state_t state_q, state_d;
  logic [1:0] word_q, word_d;
  logic req_q, req_d;
  logic [7:0] addr_d, addr_q;
  logic [15:0] act_word_q, rev_word_q, link_word_q;
  lnd_led_ctl_t led_q, led_d;
  lnd_pwr_cfg_t pwr_q, pwr_d;
  logic off_meta_q, off_sync_q;
  logic pdown_q, pdown_d;
  logic phy_pd_q, phy_ed_q;
  logic [7:0] rev_q;
  logic [23:0] class_q;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [BLINK_CNT_W-1:0] bcnt_q, bcnt_d;
  logic bphase_q, bphase_d;
  logic done_q;

  // reset image of the led register
  localparam lnd_led_ctl_t LED_RST = '{
    act: '{blink_en: 1'b1, polarity_flip: 1'b0, source_sel: ACT_SEL_RST},
    gig: '{blink_en: 1'b0, polarity_flip: 1'b0, source_sel: GIG_SEL_RST},
    link: '{blink_en: 1'b0, polarity_flip: 1'b0, source_sel: LINK_SEL_RST},
    blink_fast: 1'b0
  };

  // loader sequencing: three words in a fixed order
  wire logic got_word = (state_q == LD_WAIT) && nvm_rd_valid;
  wire logic is_done = (state_q == LD_DONE);
  wire logic [7:0] word_addr = (word_q == 2'd0) ? WIDX_ACT_LED :
                               (word_q == 2'd1) ? WIDX_REV_PWR : WIDX_LINK_LED;

  always_comb begin
    state_d = state_q;
    word_d = word_q;
    req_d = 1'b0;
    addr_d = addr_q;
    unique case (state_q)
      LD_REQ: begin // issue one read per word
        req_d = 1'b1;
        addr_d = word_addr;
        state_d = LD_WAIT;
      end
      LD_WAIT: begin
        if (nvm_rd_valid) begin
          if (word_q == 2'd2) begin
            state_d = LD_DONE;
          end else begin
            word_d = word_q + 2'd1;
            state_d = LD_REQ;
          end
        end
      end
      LD_DONE: begin
        state_d = LD_DONE;
      end
      default: begin
        state_d = LD_REQ;
      end
    endcase
  end

  // bus decode, only once loading has finished
  wire logic acc = (avs_read || avs_write) && wait_q && is_done;
  wire logic wr_go = avs_write && !wait_q;
  wire logic sel_led = (avs_address == OFS_LED_CTL);
  wire logic sel_pwr = (avs_address == OFS_PWR_CFG);
  wire logic sel_id = (avs_address == OFS_ID_CFG);
  wire logic sel_st = (avs_address == OFS_STATUS);
  wire logic sel_act = (avs_address == OFS_ACT_WORD);
  wire logic sel_rev = (avs_address == OFS_REV_WORD);
  wire logic sel_lnk = (avs_address == OFS_LINK_WORD);
  wire logic [31:0] wd = avs_writedata;

  // register views, status aside, in nvm word layout
  wire logic [31:0] led_view = {16'h0,
    led_q.gig.blink_en, led_q.gig.polarity_flip, 2'b00,
    led_q.gig.source_sel, led_q.link.blink_en, led_q.link.polarity_flip,
    led_q.blink_fast, 1'b0, led_q.link.source_sel} |
    {8'h0, led_q.act.blink_en, led_q.act.polarity_flip, 2'b00,
    led_q.act.source_sel, 16'h0};
  wire logic [31:0] pwr_view = {16'h0, pwr_q.static_off_en,
    pwr_q.dynamic_off_en, 4'h0, pwr_q.phy_off_state_policy, 8'h0};
  wire logic [31:0] id_view = {20'h0, pwr_q.class_alt, 3'b000,
    pwr_q.revision_xor_value};
  wire logic [31:0] st_view = {16'h0, rev_q, 5'h0, off_sync_q, pdown_q,
    1'b1};
  wire logic [31:0] rd_mux = sel_led ? led_view :
                             sel_pwr ? pwr_view :
                             sel_id ? id_view :
                             sel_st ? st_view :
                             sel_act ? {16'h0, act_word_q} :
                             sel_rev ? {16'h0, rev_word_q} :
                             sel_lnk ? {16'h0, link_word_q} : 32'h0;

  // waitrequest drops for one cycle after a request is seen
  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if (acc) begin
      wait_d = 1'b0;
      rdata_d = avs_read ? rd_mux : 32'h0;
    end
  end

  // live led fields: nvm load first, software writes afterwards
  always_comb begin
    led_d = led_q;
    if (got_word && word_q == 2'd0) begin
      led_d.act.blink_en = nvm_rd_data[ACT_BLINK_BIT];
      led_d.act.polarity_flip = nvm_rd_data[ACT_FLIP_BIT];
      led_d.act.source_sel = nvm_rd_data[ACT_SEL_LSB +: 4];
    end
    if (got_word && word_q == 2'd2) begin
      led_d.gig.blink_en = nvm_rd_data[GIG_BLINK_BIT];
      led_d.gig.polarity_flip = nvm_rd_data[GIG_FLIP_BIT];
      led_d.gig.source_sel = nvm_rd_data[GIG_SEL_LSB +: 4];
      led_d.link.blink_en = nvm_rd_data[LINK_BLINK_BIT];
      led_d.link.polarity_flip = nvm_rd_data[LINK_FLIP_BIT];
      led_d.blink_fast = nvm_rd_data[BLINK_RATE_BIT];
      led_d.link.source_sel = nvm_rd_data[LINK_SEL_LSB +: 4];
    end
    if (wr_go && sel_led) begin // software write wins after load
      led_d.act.blink_en = wd[16 + ACT_BLINK_BIT];
      led_d.act.polarity_flip = wd[16 + ACT_FLIP_BIT];
      led_d.act.source_sel = wd[16 + ACT_SEL_LSB +: 4];
      led_d.gig.blink_en = wd[GIG_BLINK_BIT];
      led_d.gig.polarity_flip = wd[GIG_FLIP_BIT];
      led_d.gig.source_sel = wd[GIG_SEL_LSB +: 4];
      led_d.link.blink_en = wd[LINK_BLINK_BIT];
      led_d.link.polarity_flip = wd[LINK_FLIP_BIT];
      led_d.blink_fast = wd[BLINK_RATE_BIT];
      led_d.link.source_sel = wd[LINK_SEL_LSB +: 4];
    end
  end

  // power and identity fields from the revision word or software
  always_comb begin
    pwr_d = pwr_q;
    if (got_word && word_q == 2'd1) begin
      pwr_d.static_off_en = nvm_rd_data[STATIC_OFF_BIT];
      pwr_d.dynamic_off_en = nvm_rd_data[DYN_OFF_BIT];
      pwr_d.phy_off_state_policy = nvm_rd_data[PHY_POL_LSB +: 2];
      pwr_d.class_alt = nvm_rd_data[CLASS_SEL_BIT];
      pwr_d.revision_xor_value = nvm_rd_data[REV_XOR_LSB +: 8];
    end
    if (wr_go && sel_pwr) begin
      pwr_d.static_off_en = wd[STATIC_OFF_BIT];
      pwr_d.dynamic_off_en = wd[DYN_OFF_BIT];
      pwr_d.phy_off_state_policy = wd[PHY_POL_LSB +: 2];
    end
    if (wr_go && sel_id) begin
      pwr_d.class_alt = wd[CLASS_SEL_BIT];
      pwr_d.revision_xor_value = wd[REV_XOR_LSB +: 8];
    end
  end

  // power-down decision; both modes simply or together if misprogrammed
  always_comb begin
    pdown_d = (pwr_q.static_off_en && !off_sync_q) ||
              (pwr_q.dynamic_off_en && pcie_link_dr &&
               !phy_wol_needed);
  end

  // shared blink timebase, half period per selected rate
  wire logic [BLINK_CNT_W-1:0] half_per = led_q.blink_fast ?
    BLINK_CNT_W'(BLINK_FAST - 1) : BLINK_CNT_W'(BLINK_SLOW - 1);
  always_comb begin
    bcnt_d = bcnt_q + 1'b1;
    bphase_d = bphase_q;
    if (bcnt_q >= half_per) begin
      bcnt_d = '0;
      bphase_d = !bphase_q;
    end
  end

  // loader and bus flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= LD_REQ;
      done_q <= 1'b0;
      word_q <= 2'd0;
      req_q <= 1'b0;
      addr_q <= 8'h0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      done_q <= (state_d == LD_DONE); // done flag straight from a flop
      word_q <= word_d;
      req_q <= req_d;
      addr_q <= addr_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // captured raw words for readback
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      act_word_q <= 16'h0;
      rev_word_q <= 16'h0;
      link_word_q <= 16'h0;
    end else if (got_word) begin
      if (word_q == 2'd0) act_word_q <= nvm_rd_data;
      if (word_q == 2'd1) rev_word_q <= nvm_rd_data;
      if (word_q == 2'd2) link_word_q <= nvm_rd_data;
    end
  end

  // live configuration flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      led_q <= LED_RST;
      pwr_q <= '0;
    end else begin
      led_q <= led_d;
      pwr_q <= pwr_d;
    end
  end

  // off pin synchroniser, then power and identity outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      off_meta_q <= 1'b1;
      off_sync_q <= 1'b1;
      pdown_q <= 1'b0;
      phy_pd_q <= 1'b0;
      phy_ed_q <= 1'b0;
      rev_q <= HW_REV_ID;
      class_q <= LAN_CLASS;
    end else begin
      off_meta_q <= power_off_request_n;
      off_sync_q <= off_meta_q;
      pdown_q <= pdown_d;
      phy_pd_q <= pdown_d &&
        (pwr_q.phy_off_state_policy != PHY_POL_NONE);
      phy_ed_q <= pdown_d &&
        (pwr_q.phy_off_state_policy == PHY_POL_ED);
      rev_q <= HW_REV_ID ^ pwr_q.revision_xor_value;
      class_q <= pwr_q.class_alt ? ALT_CLASS : LAN_CLASS;
    end
  end

  // blink timebase flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bcnt_q <= '0;
      bphase_q <= 1'b0;
    end else begin
      bcnt_q <= bcnt_d;
      bphase_q <= bphase_d;
    end
  end

  // outputs straight from flops
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign nvm_rd_req = req_q;
  assign nvm_rd_addr = addr_q;
  assign led_control_reg = led_q;
  assign blink_phase = bphase_q;
  assign device_power_down = pdown_q;
  assign phy_power_down = phy_pd_q;
  assign phy_energy_detect = phy_ed_q;
  assign revision_id = rev_q;
  assign class_code = class_q;
  assign load_done = done_q;

endmodule

// ===== lnd_loader_assertions.sv
// checker: bus answer, load order and reset values of lnd_loader
// assumes it is bound to every lnd_loader instance
`timescale 1ns/10ps
module lnd_loader_assertions
  import lnd_pkg::*;
#(
  parameter logic [7:0] HW_REV_ID = 8'h01
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic nvm_rd_req,
  input wire logic [7:0] nvm_rd_addr,
  input wire logic nvm_rd_valid,
  input wire lnd_pkg::lnd_led_ctl_t led_control_reg,
  input wire logic [7:0] revision_id,
  input wire logic [23:0] class_code,
  input wire logic load_done
);
  // one load step: word a arrives, word b is asked for
  sequence s_got(logic [7:0] a);
    nvm_rd_valid && nvm_rd_addr == a && !load_done;
  endsequence
  sequence s_ask(logic [7:0] b);
    ##2 nvm_rd_req && nvm_rd_addr == b;
  endsequence

  property p_step(logic [7:0] a, logic [7:0] b);
    @(posedge clk_sys) disable iff (!rst_n) s_got(a) |-> s_ask(b);
  endproperty

  a_act_then_rev: assert property (p_step(8'h1c, 8'h1e))
    else $error("revision word not asked after activity word");
  a_rev_then_link: assert property (p_step(8'h1e, 8'h1f))
    else $error("link word not asked after revision word");
  a_done_after_link: assert property (@(posedge clk_sys)
    disable iff (!rst_n) s_got(8'h1f) |=> load_done)
    else $error("load done late after last word");
  a_done_holds: assert property (@(posedge clk_sys)
    disable iff (!rst_n) load_done |=> load_done && !nvm_rd_req)
    else $error("store read again after load");
  a_req_pulse: assert property (@(posedge clk_sys)
    disable iff (!rst_n) nvm_rd_req |=> !nvm_rd_req)
    else $error("store request longer than one cycle");
  a_no_early_answer: assert property (@(posedge clk_sys)
    disable iff (!rst_n) !load_done |-> avs_waitrequest)
    else $error("bus answered before load done");
  a_answer_next: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (avs_read || avs_write) && avs_waitrequest && load_done
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");
  a_reset_defaults: assert property (@(posedge clk_sys)
    !rst_n |=> !load_done && !nvm_rd_req && revision_id == HW_REV_ID
    && class_code == LAN_CLASS
    && led_control_reg == {6'h24, 6'h07, 6'h06, 1'b0})
    else $error("wrong values after reset");
endmodule

bind lnd_loader lnd_loader_assertions #(.HW_REV_ID(HW_REV_ID)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .nvm_rd_req(nvm_rd_req), .nvm_rd_addr(nvm_rd_addr),
  .nvm_rd_valid(nvm_rd_valid), .led_control_reg(led_control_reg),
  .revision_id(revision_id), .class_code(class_code),
  .load_done(load_done));

// ===== lnd_nvm_model.sv
// store model: serves the three configuration words on request
// assumes one request at a time, same clock as the loader
`timescale 1ns/10ps
module lnd_nvm_model #(
  parameter int DLY = 4,
  parameter logic [15:0] W_ACT = 16'h0049,
  parameter logic [15:0] W_REV = 16'h8a3c, // one off mode only
  parameter logic [15:0] W_LINK = 16'hc9e3 // bit 4 kept zero
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic nvm_rd_req,
  input wire logic [7:0] nvm_rd_addr,
  output logic [15:0] nvm_rd_data,
  output logic nvm_rd_valid
);
  int cnt;
  logic [7:0] a;
  // prompt for the first word, slow for the rest; data churns when idle
  always @(posedge clk_sys) begin
    nvm_rd_valid <= 1'b0;
    nvm_rd_data <= ~nvm_rd_data;
    if (!rst_n) begin
      cnt <= 0;
      nvm_rd_data <= 16'h0;
    end else if (nvm_rd_req) begin
      a <= nvm_rd_addr;
      cnt <= (nvm_rd_addr == 8'h1c) ? 1 : DLY;
    end else if (cnt == 1) begin
      nvm_rd_valid <= 1'b1;
      nvm_rd_data <= a == 8'h1c ? W_ACT : a == 8'h1e ? W_REV : W_LINK;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ===== lnd_loader_tb.sv
// testbench for lnd_loader: load, register map, power outputs, blink
// assumes lnd_nvm_model on the store port and a 20 MHz clk_sys
`timescale 1ns/10ps
module lnd_loader_tb;
  import lnd_pkg::*;
  localparam logic [23:0] ALT = 24'h0c8000; // arbitrary value
  typedef struct packed {
    logic [15:0] cfg;
    logic [2:0] ins;
    logic [2:0] exp;
  } lnd_row_t;
  // power config, off_n/dr/wol, expected pd/phy/energy detect
  lnd_row_t rows [6] = '{{16'h8200, 6'h06}, {16'h8200, 6'h30},
    {16'h4100, 6'h37}, {16'h4100, 6'h38}, {16'h4000, 6'h34},
    {16'h0300, 6'h10}};
  logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address, nvm_rd_addr, revision_id;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] nvm_rd_data;
  logic nvm_rd_req, nvm_rd_valid, off_n, dr, wol, blink_phase;
  logic pd, phy_pd, phy_ed, load_done;
  logic [23:0] class_code;
  lnd_led_ctl_t led;
  int err_count, check_count;
  wire logic [31:0] pwr_out = {29'h0, pd, phy_pd, phy_ed};
  // led register images: loaded from the model, written by software
  localparam lnd_led_ctl_t LED_LOADED = {6'h19, 6'h39, 6'h33, 1'b1};
  localparam lnd_led_ctl_t LED_SW = {6'h22, 6'h0a, 6'h01, 1'b0};

  lnd_loader #(.ALT_CLASS(ALT), .BLINK_SLOW(10), .BLINK_FAST(4))
  u_lnd_loader (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .nvm_rd_req(nvm_rd_req),
    .nvm_rd_addr(nvm_rd_addr), .nvm_rd_data(nvm_rd_data),
    .nvm_rd_valid(nvm_rd_valid), .power_off_request_n(off_n),
    .pcie_link_dr(dr), .phy_wol_needed(wol), .led_control_reg(led),
    .blink_phase(blink_phase), .device_power_down(pd),
    .phy_power_down(phy_pd), .phy_energy_detect(phy_ed),
    .revision_id(revision_id), .class_code(class_code),
    .load_done(load_done));

  lnd_nvm_model u_lnd_nvm_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .nvm_rd_req(nvm_rd_req), .nvm_rd_addr(nvm_rd_addr),
    .nvm_rd_data(nvm_rd_data), .nvm_rd_valid(nvm_rd_valid));

  // free running core clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one avalon access; holds until waitrequest is sampled low
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 300);
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      wrap_up();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (load_done !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    if (load_done !== 1'b1) begin
      err_count++;
      wrap_up();
    end
  endtask

  // cycles between two toggles of the blink square wave
  task automatic half(int exp);
    int t;
    logic b;
    for (int k = 0; k < 2; k++) begin
      b = blink_phase;
      t = 0;
      while (blink_phase === b && t < 100) begin
        @(posedge clk_sys);
        t++;
      end
    end
    chk("blink half period", t, exp);
    $display("blink test done");
  endtask

  // main sequence
  initial begin
    err_count = 0;
    check_count = 0;
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    off_n = 1'b1;
    dr = 1'b0;
    wol = 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("act reset", {26'h0, led.act}, 32'h24);
    chk("gig reset", {26'h0, led.gig}, 32'h07);
    chk("link reset", {26'h0, led.link}, 32'h06);
    chk("rate reset", {31'h0, led.blink_fast}, 32'h0);
    rst_n <= 1'b1;
    wait_done();
    @(posedge clk_sys);
    chk("act loaded", {26'h0, led.act}, 32'h19);
    chk("gig loaded", {26'h0, led.gig}, 32'h39);
    chk("link loaded", {26'h0, led.link}, 32'h33);
    chk("rate loaded", {31'h0, led.blink_fast}, 32'h1);
    chk("rev", {24'h0, revision_id}, 32'h3d);
    chk("class alt", {8'h0, class_code}, {8'h0, ALT});
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status", rd, 32'h3d05);
    $display("load test done");
    half(4);
    foreach (rows[i]) begin
      bus(1'b1, OFS_PWR_CFG, {16'h0, rows[i].cfg});
      {off_n, dr, wol} <= rows[i].ins;
      repeat (6) @(posedge clk_sys);
      chk("power out", pwr_out, {29'h0, rows[i].exp});
      bus(1'b0, OFS_PWR_CFG, 32'h0);
      chk("power reg", rd, {16'h0, rows[i].cfg});
    end
    $display("power test done");
    bus(1'b1, OFS_ID_CFG, 32'h0000085a);
    @(posedge clk_sys); // revision register follows the field a cycle later
    chk("rev written", {24'h0, revision_id}, 32'h5b);
    bus(1'b1, OFS_ID_CFG, 32'h0);
    @(posedge clk_sys);
    chk("rev plain", {24'h0, revision_id}, 32'h01);
    chk("class lan", {8'h0, class_code}, {8'h0, LAN_CLASS});
    bus(1'b1, OFS_LED_CTL, 32'h00820a01);
    chk("led written", {13'h0, led}, {13'h0, LED_SW});
    half(10);
    bus(1'b1, OFS_ACT_WORD, 32'hffff);
    bus(1'b0, OFS_ACT_WORD, 32'h0);
    chk("raw act", rd, 32'h0049);
    bus(1'b0, OFS_LINK_WORD, 32'h0);
    chk("raw link", rd, 32'hc9e3);
    bus(1'b1, 8'h40, 32'h1234);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("early done", {31'h0, load_done}, 32'h0);
    // read raised while loading: held off until all three words are in
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status reload", rd, 32'h3d03);
    wait_done();
    @(posedge clk_sys);
    chk("led reloaded", {13'h0, led}, {13'h0, LED_LOADED});
    $display("reset test done");
    wrap_up();
  end
endmodule
